/* logic/page_access_protection_check.sv */
`include "page_access_protection_check_map.svh"

module page_access_protection_check
    import page_access_protection_check_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Access from the pipeline.
    input wire logic access_valid,
    input wire access_kind_t access_kind,
    input wire logic privilege_mode_bit,
    input wire logic no_execute_bit,
    input wire logic entry_cached,
    input wire logic [1:0] page_protection_bits,
    input wire logic guarded_bit,
    // Decision.
    output logic access_permit,
    output logic instruction_storage_exception,
    output logic data_storage_exception,
    output logic referenced_bit_set,
    output logic changed_bit_set,
    // Table search request.
    output logic walk_req,
    output logic walk_physical,
    output logic walk_coherence_required_attr,
    // Segment state.
    output logic [31:0] segment_table_address,
    // AXI4-Lite slave.
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    logic [1:0] keys_q;
    logic [31:0] seg_addr_q;
    logic [31:0] dfs_q;
    logic [63:0] srs_q;
    logic key;
    logic is_write;
    logic is_fetch;
    logic pp_viol;
    logic fetch_block;
    logic viol;
    logic judged;

    // The unselected key never reaches the decision.
    assign key = privilege_mode_bit ? keys_q[`KEYS_USER_BIT]
                                    : keys_q[`KEYS_SUPERVISOR_BIT];
    assign is_fetch = (access_kind == ACC_FETCH);
    // Fetches are judged as reads.
    assign is_write = (access_kind == ACC_STORE);
    assign fetch_block = is_fetch & (no_execute_bit | guarded_bit);

    always_comb begin
        unique case (page_protection_bits)
            PP_00: pp_viol = key;
            PP_01: pp_viol = key & is_write;
            PP_10: pp_viol = 1'b0;
            PP_11: pp_viol = is_write;
        endcase
    end

    // Without a cached entry the decision waits for the search.
    assign judged = access_valid & entry_cached;
    // Pure logic so the request lands in the access cycle.
    assign viol = judged & (pp_viol | fetch_block);
    assign access_permit = judged & ~viol;
    assign instruction_storage_exception = viol & is_fetch;
    assign data_storage_exception = viol & ~is_fetch;
    assign referenced_bit_set = judged;
    assign changed_bit_set = judged & is_write & ~viol;
    assign walk_req = access_valid & ~entry_cached;
    assign walk_physical = 1'b1;
    assign walk_coherence_required_attr = 1'b1;
    assign segment_table_address = seg_addr_q;

    // AXI write path.
    logic aw_have_q;
    logic w_have_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic do_write;
    logic wr_priv_ok;
    logic wr_known;

    assign s_axi_awready = ~aw_have_q & ~bvalid_q;
    assign s_axi_wready = ~w_have_q & ~bvalid_q;
    assign do_write = aw_have_q & w_have_q & ~bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    always_comb begin
        wr_known = 1'b1;
        unique case (aw_addr_q)
            `OFS_DATA_FAULT_STATUS, `OFS_SAVE_RESTORE_LO,
            `OFS_SAVE_RESTORE_HI, `OFS_SEGMENT_KEYS,
            `OFS_SEGMENT_TABLE_ADDR: wr_known = 1'b1;
            default: wr_known = 1'b0;
        endcase
    end

    // User-mode writes to segment state are refused with SLVERR.
    assign wr_priv_ok = ~privilege_mode_bit |
                        ((aw_addr_q != `OFS_SEGMENT_KEYS) &&
                         (aw_addr_q != `OFS_SEGMENT_TABLE_ADDR));

    always_ff @(posedge clk) begin
        if (rst) begin
            aw_have_q <= 1'b0;
            aw_addr_q <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end else if (do_write) begin
            aw_have_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            w_have_q <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end else if (do_write) begin
            w_have_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            bvalid_q <= 1'b0;
            bresp_q <= `RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q <= (wr_known && wr_priv_ok) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    logic [31:0] wmask;
    logic wr_ok;
    assign wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
                    {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
    assign wr_ok = do_write & wr_priv_ok;

    always_ff @(posedge clk) begin
        if (rst) begin
            keys_q <= `RST_SEGMENT_KEYS;
        end else if (wr_ok && aw_addr_q == `OFS_SEGMENT_KEYS
                     && w_strb_q[0]) begin
            keys_q <= w_data_q[1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            seg_addr_q <= `RST_SEGMENT_TABLE_ADDR;
        end else if (wr_ok && aw_addr_q == `OFS_SEGMENT_TABLE_ADDR) begin
            seg_addr_q <= (seg_addr_q & ~wmask) | (w_data_q & wmask);
        end
    end

    // Status bits are write-one-to-clear; a new fault wins over the clear.
    logic [31:0] dfs_clr;
    logic [31:0] dfs_set;
    logic [63:0] srs_clr;
    logic [63:0] srs_set;

    always_comb begin
        dfs_clr = 32'h0000_0000;
        srs_clr = 64'h0000_0000_0000_0000;
        if (do_write && aw_addr_q == `OFS_DATA_FAULT_STATUS) begin
            dfs_clr = w_data_q & wmask;
        end
        if (do_write && aw_addr_q == `OFS_SAVE_RESTORE_LO) begin
            srs_clr[31:0] = w_data_q & wmask;
        end
        if (do_write && aw_addr_q == `OFS_SAVE_RESTORE_HI) begin
            srs_clr[63:32] = w_data_q & wmask;
        end
        dfs_set = 32'h0000_0000;
        srs_set = 64'h0000_0000_0000_0000;
        dfs_set[`DFS_PROHIBITED_BIT] = data_storage_exception;
        dfs_set[`DFS_STORE_BIT] = data_storage_exception & is_write;
        srs_set[`SRS_NO_EXEC_BIT] = instruction_storage_exception
                                    & no_execute_bit;
        srs_set[`SRS_PROTECT_BIT] = instruction_storage_exception
                                    & ~no_execute_bit;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            dfs_q <= `RST_DATA_FAULT_STATUS;
        end else begin
            dfs_q <= (dfs_q & ~dfs_clr) | dfs_set;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            srs_q <= `RST_SAVE_RESTORE;
        end else begin
            srs_q <= (srs_q & ~srs_clr) | srs_set;
        end
    end

    // AXI read path, answered one cycle after the address is taken.
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic [31:0] rd_word;
    logic rd_known;

    assign s_axi_arready = ~rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    always_comb begin
        rd_word = 32'h0000_0000;
        rd_known = 1'b1;
        unique case (s_axi_araddr)
            `OFS_DATA_FAULT_STATUS: rd_word = dfs_q;
            `OFS_SAVE_RESTORE_LO: rd_word = srs_q[31:0];
            `OFS_SAVE_RESTORE_HI: rd_word = srs_q[63:32];
            `OFS_SEGMENT_KEYS: rd_word = {30'h0, keys_q};
            `OFS_SEGMENT_TABLE_ADDR: rd_word = seg_addr_q;
            default: rd_known = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= rd_known ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // Checks next to the logic they guard.
    a_key_pick_user: assert property (@(posedge clk) disable iff (rst)
        judged && privilege_mode_bit && !keys_q[`KEYS_USER_BIT]
        && page_protection_bits == 2'h0 && !is_fetch |-> access_permit)
        else $error("user key zero must allow protection 00");
    a_fetch_block: assert property (@(posedge clk) disable iff (rst)
        judged && is_fetch && (no_execute_bit || guarded_bit)
        |-> instruction_storage_exception && !access_permit)
        else $error("blocked fetch not refused");
    a_key1_pp00: assert property (@(posedge clk) disable iff (rst)
        judged && key && page_protection_bits == 2'h0 |-> viol)
        else $error("key 1 protection 00 must refuse");
    a_key1_pp01: assert property (@(posedge clk) disable iff (rst)
        judged && key && page_protection_bits == 2'h1 && !fetch_block
        |-> viol == is_write)
        else $error("key 1 protection 01 wrong");
    a_pp10_open: assert property (@(posedge clk) disable iff (rst)
        judged && page_protection_bits == 2'h2 && !is_fetch
        |-> access_permit)
        else $error("protection 10 must allow");
    a_pp11_ro: assert property (@(posedge clk) disable iff (rst)
        judged && page_protection_bits == 2'h3 && is_write |-> viol)
        else $error("protection 11 write not refused");
    a_dfs_record: assert property (@(posedge clk) disable iff (rst)
        data_storage_exception && is_write
        |=> dfs_q[`DFS_PROHIBITED_BIT] && dfs_q[`DFS_STORE_BIT])
        else $error("store fault status not recorded");
    a_srs_record: assert property (@(posedge clk) disable iff (rst)
        instruction_storage_exception && no_execute_bit
        |=> srs_q[`SRS_NO_EXEC_BIT])
        else $error("no-execute status not recorded");
    a_no_change: assert property (@(posedge clk) disable iff (rst)
        viol |-> !changed_bit_set)
        else $error("changed bit set on refused access");
    a_walk_miss: assert property (@(posedge clk) disable iff (rst)
        access_valid && !entry_cached |-> walk_req && !access_permit
        && !instruction_storage_exception && !data_storage_exception)
        else $error("miss judged without search");
    a_key_guard: assert property (@(posedge clk) disable iff (rst)
        do_write && privilege_mode_bit && aw_addr_q == `OFS_SEGMENT_KEYS
        |=> $stable(keys_q) && s_axi_bresp == `RESP_SLVERR)
        else $error("user write changed segment keys");

endmodule

/* common/page_access_protection_check_map.svh */
`ifndef PAGE_ACCESS_PROTECTION_CHECK_MAP_SVH
`define PAGE_ACCESS_PROTECTION_CHECK_MAP_SVH

// Register byte offsets.
`define OFS_DATA_FAULT_STATUS 8'h00
`define OFS_SAVE_RESTORE_LO 8'h04
`define OFS_SAVE_RESTORE_HI 8'h08
`define OFS_SEGMENT_KEYS 8'h0C
`define OFS_SEGMENT_TABLE_ADDR 8'h10

// Field positions.
`define DFS_PROHIBITED_BIT 4
`define DFS_STORE_BIT 6
`define SRS_PROTECT_BIT 36
`define SRS_NO_EXEC_BIT 35
`define KEYS_SUPERVISOR_BIT 0
`define KEYS_USER_BIT 1

// Reset values.
`define RST_DATA_FAULT_STATUS 32'h0000_0000
`define RST_SAVE_RESTORE 64'h0000_0000_0000_0000
`define RST_SEGMENT_KEYS 2'h0
`define RST_SEGMENT_TABLE_ADDR 32'h0000_0000

// AXI responses.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* common/page_access_protection_check_pkg.sv */
package page_access_protection_check_pkg;

    typedef enum logic [1:0] {
        ACC_FETCH = 2'b00,
        ACC_LOAD = 2'b01,
        ACC_STORE = 2'b10
    } access_kind_t;

    typedef enum logic [1:0] {
        PP_00 = 2'b00,
        PP_01 = 2'b01,
        PP_10 = 2'b10,
        PP_11 = 2'b11
    } page_prot_t;

endpackage

/* tb/pipe_model.sv */
module pipe_model
    import page_access_protection_check_pkg::*;
(
    // Access lines toward the checker.
    output logic access_valid,
    output access_kind_t access_kind,
    output logic privilege_mode_bit,
    output logic no_execute_bit,
    output logic entry_cached,
    output logic [1:0] page_protection_bits,
    output logic guarded_bit
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        access_valid = 1'h0;
        access_kind = ACC_LOAD;
        privilege_mode_bit = 1'h0;
        no_execute_bit = 1'h0;
        entry_cached = 1'h0;
        page_protection_bits = 2'h0;
        guarded_bit = 1'h0;
    end

    // Idle lines flip to the inverse of the value they hold, so a stale value
    // can never pass for a live one. The mode bit is state, driven from pr on every call.
    task automatic drive(input logic v, input access_kind_t k,
                         input logic pr, nx, ca, input logic [1:0] pp,
                         input logic g);
        access_valid <= v;
        privilege_mode_bit <= pr;
        access_kind <= v ? k : access_kind_t'(~access_kind);
        no_execute_bit <= v ? nx : ~no_execute_bit;
        entry_cached <= v ? ca : ~entry_cached;
        page_protection_bits <= v ? pp : ~page_protection_bits;
        guarded_bit <= v ? g : ~guarded_bit;
    endtask
endmodule

/* tb/page_access_protection_check_tb.sv */
`include "page_access_protection_check_map.svh"
module page_access_protection_check_tb
    import page_access_protection_check_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'h0;
    logic rst = 1'h1;
    logic access_valid, privilege_mode_bit, no_execute_bit;
    logic entry_cached, guarded_bit;
    access_kind_t access_kind;
    logic [1:0] page_protection_bits, bresp, rresp;
    logic permit, ise, dse, rb, cb, wq, wp, wc;
    logic [31:0] sta, wdata, rdata, dfs, shi;
    logic [7:0] awaddr, araddr;
    logic [3:0] wstrb;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, ks, ku;
    int fail_count = 0;
    int num_checks = 0;
    int seed = 32'h1db4;
    logic [7:0] aq[$];
    logic [33:0] rq[$];

    always #5 clk = ~clk;

    pipe_model pipe_model_i (.access_valid(access_valid),
        .access_kind(access_kind), .privilege_mode_bit(privilege_mode_bit),
        .no_execute_bit(no_execute_bit), .entry_cached(entry_cached),
        .page_protection_bits(page_protection_bits),
        .guarded_bit(guarded_bit));

    page_access_protection_check page_access_protection_check_i (
        .clk(clk), .rst(rst), .access_valid(access_valid),
        .access_kind(access_kind), .privilege_mode_bit(privilege_mode_bit),
        .no_execute_bit(no_execute_bit), .entry_cached(entry_cached),
        .page_protection_bits(page_protection_bits),
        .guarded_bit(guarded_bit), .access_permit(permit),
        .instruction_storage_exception(ise), .data_storage_exception(dse),
        .referenced_bit_set(rb), .changed_bit_set(cb), .walk_req(wq),
        .walk_physical(wp), .walk_coherence_required_attr(wc),
        .segment_table_address(sta), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));

    task automatic chk(input string nm, input logic [63:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic [1:0] er);
        int n;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
            if (bvalid) break;
        end
        if (n == 50) begin
            fail_count++;
            close_out();
        end
        chk("bresp", bresp, er);
        bready <= 1'h0;
        @(posedge clk);
    endtask

    // The expected word goes on the queue before the request is made.
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        int n;
        rq.push_back(e);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (arready) arvalid <= 1'h0;
            if (rvalid) break;
        end
        if (n == 50) begin
            fail_count++;
            close_out();
        end
        rready <= 1'h0;
        @(posedge clk);
    endtask

    task automatic acc(input access_kind_t k, input logic pr, nx, ca,
                       input logic [1:0] pp, input logic g);
        logic key, st, f, v;
        key = pr ? ku : ks;
        st = (k == ACC_STORE);
        f = (k == ACC_FETCH);
        v = (key && pp == 2'h0) || (key && pp == 2'h1 && st)
            || (pp == 2'h3 && st) || (f && (nx || g));
        if (!ca)
            aq.push_back(8'h07);
        else
            aq.push_back({!v, f && v, !f && v, 1'h1, st && !v,
                          3'h3});
        if (ca && v && !f) dfs = dfs | (st ? 32'h50 : 32'h10);
        if (ca && v && f) shi = shi | (nx ? 32'h8 : 32'h10);
        pipe_model_i.drive(1'h1, k, pr, nx, ca, pp, g);
        @(posedge clk);
    endtask

    // Decisions are combinational, so they are judged in the access cycle.
    always @(posedge clk) begin
        if (access_valid) begin
            if (aq.size() == 0) chk("access queue", 1, 0);
            else chk("decision", {permit, ise, dse, rb, cb, wq, wp, wc},
                     aq.pop_front());
        end
        if (rvalid && rready) begin
            if (rq.size() == 0) chk("read queue", 1, 0);
            else chk("rdata", {rresp, rdata}, rq.pop_front());
        end
    end

    initial begin
        int i;
        logic [31:0] r;
        {awvalid, wvalid, arvalid, bready, rready} = 5'h0;
        {awaddr, araddr, wdata, wstrb} = 52'h0;
        {ks, ku, dfs, shi} = 66'h0;
        repeat (8) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        for (i = 0; i < 5; i++) rd(8'(i * 4), {`RESP_OKAY, 32'h0});
        rd(8'h14, {`RESP_SLVERR, 32'h0});
        wr(8'h14, 32'hFFFF_FFFF, 4'hF, `RESP_SLVERR);
        $display("test reset_map done");
        pipe_model_i.drive(1'h0, ACC_LOAD, 1'h1, 1'h0, 1'h0, 2'h0, 1'h0);
        @(posedge clk);
        wr(`OFS_SEGMENT_KEYS, 32'h3, 4'hF, `RESP_SLVERR);
        wr(`OFS_SEGMENT_TABLE_ADDR, 32'h1234_5678, 4'hF,
           `RESP_SLVERR);
        chk("table address", sta, 32'h0);
        rd(`OFS_SEGMENT_KEYS, {`RESP_OKAY, 32'h0});
        pipe_model_i.drive(1'h0, ACC_LOAD, 1'h0, 1'h0, 1'h0, 2'h0, 1'h0);
        @(posedge clk);
        wr(`OFS_SEGMENT_TABLE_ADDR, 32'h1234_5678, 4'hF, `RESP_OKAY);
        wr(`OFS_SEGMENT_TABLE_ADDR, 32'hFFFF_FFFF, 4'h1, `RESP_OKAY);
        chk("table address", sta, 32'h1234_56FF);
        $display("test privilege done");
        for (i = 0; i < 96; i++) begin
            if (i % 16 == 0) begin
                pipe_model_i.drive(1'h0, ACC_LOAD, 1'h0, 1'h0, 1'h0, 2'h0,
                                   1'h0);
                @(posedge clk);
                ks = i[4];
                ku = i[5];
                wr(`OFS_SEGMENT_KEYS, {30'h0, ku, ks}, 4'h1, `RESP_OKAY);
            end
            r = $random(seed);
            acc(access_kind_t'(r[1:0]), r[2],
                r[3] & r[4], |r[7:5], r[9:8], r[10] & r[11]);
            if (i % 8 == 7) begin
                pipe_model_i.drive(1'h0, ACC_LOAD, r[2], 1'h0, 1'h0, 2'h0,
                                   1'h0);
                @(posedge clk);
                rd(`OFS_DATA_FAULT_STATUS, {`RESP_OKAY, dfs});
                rd(`OFS_SAVE_RESTORE_HI, {`RESP_OKAY, shi});
                rd(`OFS_SAVE_RESTORE_LO, {`RESP_OKAY, 32'h0});
                wr(`OFS_DATA_FAULT_STATUS, 32'hFFFF_FFFF, 4'hF, `RESP_OKAY);
                wr(`OFS_SAVE_RESTORE_HI, 32'hFFFF_FFFF, 4'hF, `RESP_OKAY);
                dfs = 32'h0;
                shi = 32'h0;
            end
        end
        $display("test access_sweep done");
        close_out();
    end
endmodule
